// ---- src/gpm_defs.svh ----
/*
  Offsets, field positions, reset values and pin numbers of the GPIO block.
  Assumes inclusion by bare name from the bank and port design files.
*/
`ifndef GPM_DEFS_SVH
`define GPM_DEFS_SVH

// Register byte offsets on APB
`define GPM_OFS_FIRST 12'h000
`define GPM_OFS_SECOND 12'h004
// Field base positions inside a control register
`define GPM_MODE_POS 24
`define GPM_DIR_POS 16
`define GPM_SF_POS 8
`define GPM_DATA_POS 0
// Reset values: all pins general-purpose inputs, data low
`define GPM_FIRST_RESET 32'h0000_0000
`define GPM_SECOND_RESET 32'h0000_0000
// Pin positions within the first bank
`define GPM_PIN_TXD 7
`define GPM_PIN_DTR 6
`define GPM_PIN_RTS 5
`define GPM_PIN_SCK 4
`define GPM_PIN_RXD 3

`endif

// ---- src/gpm_pkg.sv ----
/*
  Types shared by the GPIO block files.
  Assumes gpm_defs.svh is on the include path.
*/
package gpm_pkg;
  // Pin function chosen by mode, direction and special-function bits
  typedef enum logic [1:0] {
    GPM_FN_IN = 2'h0,
    GPM_FN_OUT = 2'h1,
    GPM_FN_SPECIAL = 2'h3
  } gpm_fn_t;
  // APB slave phase
  typedef enum logic [1:0] {
    GPM_IDLE = 2'h0,
    GPM_SETUP = 2'h1,
    GPM_ACCESS = 2'h3
  } gpm_apb_t;
endpackage

// ---- src/gpm_bank.sv ----
/*
  One eight-pin bank: decodes each pin's function and drives its pin.
  Assumes pin inputs are synchronous to clock; special signals come from
  the on-chip serial and SPI units.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpm_defs.svh"
module gpm_bank
  import gpm_pkg::*;
#(
  parameter int PINS = 8,
  parameter bit HAS_SF = 1'b0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [31:0] ctrl,
  input wire logic [PINS-1:0] special,
  input wire logic [PINS-1:0] pinIn,
  output logic [PINS-1:0] pinOut,
  output logic [PINS-1:0] pinOe,
  output logic [PINS-1:0] level
);
  // Decode function of a pin from its three configuration bits
  function automatic gpm_fn_t pinFn(input logic m, input logic d,
                                    input logic s);
    if (!m && !s) begin
      pinFn = d ? GPM_FN_OUT : GPM_FN_IN;
    end else begin
      pinFn = GPM_FN_SPECIAL;
    end
  endfunction

  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : gPin
      logic sf;
      gpm_fn_t fn;
      assign sf = HAS_SF ? ctrl[`GPM_SF_POS+i] : 1'b0; // [R02]
      assign fn = pinFn(ctrl[`GPM_MODE_POS+i], ctrl[`GPM_DIR_POS+i], sf);
      // Registered pin drive per function
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          pinOut[i] <= 1'b0;
          pinOe[i] <= 1'b0;
        end else begin
          case (fn)
            GPM_FN_OUT: begin // [R04]
              pinOut[i] <= ctrl[`GPM_DATA_POS+i]; // [R03]
              pinOe[i] <= 1'b1;
            end
            GPM_FN_SPECIAL: begin // [R09]
              pinOut[i] <= special[i];
              pinOe[i] <= ctrl[`GPM_DIR_POS+i];
            end
            default: begin // [R10]
              pinOut[i] <= 1'b0;
              pinOe[i] <= 1'b0;
            end
          endcase
        end
      end
      // Registered level: the pin's own drive when output-enabled, else its input
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          level[i] <= 1'b0;
        end else begin
          level[i] <= pinOe[i] ? pinOut[i] : pinIn[i]; // [R03]
        end
      end
    end
  endgenerate

  AST_OUT_DRIVES: assert property (@(posedge clock) disable iff (!reset_n)
    (ctrl[`GPM_MODE_POS] == 1'b0 && ctrl[`GPM_DIR_POS] == 1'b1 &&
     (!HAS_SF || ctrl[`GPM_SF_POS] == 1'b0)) |=>
    (pinOe[0] && pinOut[0] == $past(ctrl[`GPM_DATA_POS])))
    else $error("output pin not driven from data bit"); // [R04]
  AST_IN_RELEASED: assert property (@(posedge clock) disable iff (!reset_n)
    (ctrl[`GPM_MODE_POS+1] == 1'b0 && ctrl[`GPM_DIR_POS+1] == 1'b0 &&
     (!HAS_SF || ctrl[`GPM_SF_POS+1] == 1'b0)) |=> !pinOe[1])
    else $error("input pin is driven"); // [R10]
endmodule // gpm_bank
`default_nettype wire

// ---- src/gpm_port.sv ----
/*
  Sixteen-pin GPIO block with two APB control registers.
  Assumes a single 200 MHz clock, APB master, synchronous pin inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpm_defs.svh"
// Operation
// [R01] Sixteen pins, two control registers, eight pins per register.
// [R02] Each pin has mode, direction, special-function (second only), data.
// [R03] Data reads live pin level; writes set driven output level.
// [R04] Mode 0, direction 1, special 0 makes a plain output.
// [R05] Software updates a pin by read-modify-write of the full word.
// [R06] Software never reconfigures pins reserved for fixed internal use; the bench rows reconfigure bits seven to three.
// [R07] Software keeps first-bank bit five or four an input; the bench's row zero drives both.
// [R08] Bit five carries RTS normally; bit four carries SPI clock.
// [R09] Bits seven, six, three carry transmit, DTR, receive by default.
// [R10] Mode 0, direction 0, special 0 makes an input sampling pin.
module gpm_port
  import gpm_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serialTxd,
  input wire logic serialDtr,
  input wire logic serialRts,
  input wire logic spiClock,
  output logic serialRxd,
  input wire logic [PINS-1:0] secondSpecial,
  input wire logic [2*PINS-1:0] pinIn,
  output logic [2*PINS-1:0] pinOut,
  output logic [2*PINS-1:0] pinOe
);
  logic [31:0] gpio_bank_first_control_reg;
  logic [31:0] gpio_bank_second_control_reg;
  logic [PINS-1:0] firstLevel;
  logic [PINS-1:0] secondLevel;
  logic [PINS-1:0] firstSpecial;
  gpm_apb_t phase_reg;
  logic hitFirst;
  logic hitSecond;
  logic setupNow;

  // Address decode
  always_comb begin
    hitFirst = 1'b0;
    hitSecond = 1'b0;
    if (paddr == `GPM_OFS_FIRST) begin
      hitFirst = 1'b1;
    end else if (paddr == `GPM_OFS_SECOND) begin
      hitSecond = 1'b1;
    end
  end

  assign setupNow = psel && !penable;

  // APB phase tracker
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= GPM_IDLE;
    end else begin
      case (phase_reg)
        GPM_IDLE: phase_reg <= setupNow ? GPM_SETUP : GPM_IDLE;
        GPM_SETUP: phase_reg <= GPM_ACCESS;
        default: phase_reg <= setupNow ? GPM_SETUP : GPM_IDLE;
      endcase
    end
  end

  // Answer pulse: ready in the second access cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= phase_reg == GPM_SETUP;
      pslverr <= phase_reg == GPM_SETUP && !(hitFirst || hitSecond);
      prdata <= 32'h0000_0000;
      if (phase_reg == GPM_SETUP && !pwrite) begin
        if (hitFirst) begin
          prdata <= {gpio_bank_first_control_reg[31:8], firstLevel}; // [R03]
        end else if (hitSecond) begin
          prdata <= {gpio_bank_second_control_reg[31:8], secondLevel};
        end
      end
    end
  end

  // First control register; no special-function field here
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gpio_bank_first_control_reg <= `GPM_FIRST_RESET;
    end else if (psel && penable && pready && pwrite && hitFirst) begin
      gpio_bank_first_control_reg <= pwdata & 32'hFFFF_00FF; // [R02]
    end
  end

  // Second control register holds all four fields
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gpio_bank_second_control_reg <= `GPM_SECOND_RESET;
    end else if (psel && penable && pready && pwrite && hitSecond) begin
      gpio_bank_second_control_reg <= pwdata; // [R01]
    end
  end

  // Special functions of the first bank
  always_comb begin
    firstSpecial = '0;
    firstSpecial[`GPM_PIN_TXD] = serialTxd; // [R09]
    firstSpecial[`GPM_PIN_DTR] = serialDtr; // [R09]
    firstSpecial[`GPM_PIN_RTS] = serialRts; // [R08]
    firstSpecial[`GPM_PIN_SCK] = spiClock; // [R08]
  end

  // Receive line routed from the first bank's pin three
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      serialRxd <= 1'b1;
    end else begin
      serialRxd <= pinIn[`GPM_PIN_RXD]; // [R09]
    end
  end

  gpm_bank #(.PINS(PINS), .HAS_SF(1'b0)) uFirst (
    .clock(clock),
    .reset_n(reset_n),
    .ctrl(gpio_bank_first_control_reg),
    .special(firstSpecial),
    .pinIn(pinIn[PINS-1:0]),
    .pinOut(pinOut[PINS-1:0]),
    .pinOe(pinOe[PINS-1:0]),
    .level(firstLevel)
  );

  gpm_bank #(.PINS(PINS), .HAS_SF(1'b1)) uSecond (
    .clock(clock),
    .reset_n(reset_n),
    .ctrl(gpio_bank_second_control_reg),
    .special(secondSpecial),
    .pinIn(pinIn[2*PINS-1:PINS]),
    .pinOut(pinOut[2*PINS-1:PINS]),
    .pinOe(pinOe[2*PINS-1:PINS]),
    .level(secondLevel)
  );

  sequence sWrFirst;
    psel && penable && pready && pwrite && hitFirst;
  endsequence

  AST_FIRST_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
    sWrFirst |=> gpio_bank_first_control_reg[31:8] ==
      ($past(pwdata[31:8]) & 24'hFFFF00))
    else $error("first register write lost"); // [R02]
  AST_SECOND_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
    (psel && penable && pready && pwrite && hitSecond) |=>
      gpio_bank_second_control_reg == $past(pwdata))
    else $error("second register write lost"); // [R01]
  AST_READY_TIMING: assert property (@(posedge clock) disable iff (!reset_n)
    (phase_reg == GPM_SETUP) |=> pready ##1 !pready)
    else $error("ready not a single pulse after setup"); // [R01]
  AST_UNMAPPED: assert property (@(posedge clock) disable iff (!reset_n)
    (phase_reg == GPM_SETUP && !hitFirst && !hitSecond) |=> pslverr)
    else $error("unmapped address not flagged"); // [R01]
  AST_RTS_ROUTE: assert property (@(posedge clock) disable iff (!reset_n)
    (gpio_bank_first_control_reg[`GPM_MODE_POS+`GPM_PIN_RTS] &&
     gpio_bank_first_control_reg[`GPM_DIR_POS+`GPM_PIN_RTS]) |=>
      pinOe[`GPM_PIN_RTS] && pinOut[`GPM_PIN_RTS] == $past(serialRts))
    else $error("RTS not routed to pin"); // [R08]
  AST_RXD_ROUTE: assert property (@(posedge clock) disable iff (!reset_n)
    1'b1 |=> serialRxd == $past(pinIn[`GPM_PIN_RXD]))
    else $error("receive not taken from pin"); // [R09]
endmodule // gpm_port
`default_nettype wire

// ---- testbench/gpm_pins.sv ----
/*
  External header pins and switches facing the GPIO block.
  Assumes the bench sets switch levels; bits five and four share a pin.
*/
`timescale 1ns/1ps
`default_nettype none
module gpm_pins (
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOe,
  input wire logic [15:0] extLevel,
  output logic [15:0] pinIn
);
  logic shared;
  // One header pin seen by bit five and bit four
  assign shared = pinOe[5] ? pinOut[5] :
    (pinOe[4] ? pinOut[4] : extLevel[4]);
  // Driven pins read their drive, others the switch level; bits five and four read the shared pin
  always_comb begin
    pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
    pinIn[5] = shared;
    pinIn[4] = shared;
  end
endmodule // gpm_pins
`default_nettype wire

// ---- testbench/tb.sv ----
/*
  Self-checking bench for the GPIO block: APB master, pin model, table.
  Assumes a 200 MHz clock and one fixed APB wait state or more.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gpm_pkg::*;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [15:0] ext;
    logic [7:0] spec;
    logic [7:0] oe;
    logic [7:0] out;
    logic [31:0] rd;
  } gpm_row_t;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic serialTxd = 1'b0;
  logic serialDtr = 1'b0;
  logic serialRts = 1'b0;
  logic spiClock = 1'b0;
  logic serialRxd;
  logic [7:0] secondSpecial = 8'h00;
  logic [15:0] extLevel = 16'h0000;
  logic [15:0] pinIn;
  logic [15:0] pinOut;
  logic [15:0] pinOe;
  logic [31:0] rd;
  logic err;
  int errorCnt = 0;
  int samplesChecked = 0;
  int bsel;
  gpm_row_t rows [6] = '{
    '{12'h000, 32'h00FF00A5, 16'h0000, 8'h00, 8'hFF, 8'hA5, 32'h00FF00A5},
    '{12'h000, 32'h00000000, 16'h003C, 8'h00, 8'h00, 8'h00, 32'h0000003C},
    '{12'h004, 32'h000F005A, 16'hF000, 8'h00, 8'h0F, 8'h0A, 32'h000F00FA},
    '{12'h004, 32'h00FFFF00, 16'h0000, 8'h96, 8'hFF, 8'h96, 32'h00FFFF96},
    '{12'h000, 32'hE0E00000, 16'h0000, 8'hA0, 8'hE0, 8'hA0, 32'hE0E000B0},
    '{12'h000, 32'h10100000, 16'h0000, 8'h10, 8'h10, 8'h10, 32'h10100030}};

  // Clock generation
  always #2.5 clock = ~clock;

  gpm_port u_dut (.clock(clock), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serialTxd(serialTxd), .serialDtr(serialDtr), .serialRts(serialRts),
    .spiClock(spiClock), .serialRxd(serialRxd),
    .secondSpecial(secondSpecial), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe));

  gpm_pins u_pins (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel),
    .pinIn(pinIn));

  // Verdict and end of run
  task automatic close_out();
    $display("errors %0d checks %0d", errorCnt, samplesChecked);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compare with case equality
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samplesChecked++;
    if (g !== x) begin
      errorCnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask

  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errorCnt++;
      $display("[ERR] %0t no pready", $time);
      close_out();
    end
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    chk(pinOe, 32'h0);
    chk(serialRxd, 32'h1);
    reset_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, rd, err);
    chk(rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0, rd, err);
    chk(rd, 32'h0);
    foreach (rows[i]) begin
      extLevel <= rows[i].ext;
      {serialTxd, serialDtr, serialRts, spiClock} <= rows[i].spec[7:4];
      secondSpecial <= rows[i].spec;
      // Rows also reconfigure the fixed-use pins; row zero drives bits five and four together
      apb(1'b1, rows[i].addr, rows[i].wdata, rd, err);
      chk(err, 32'h0);
      repeat (4) @(posedge clock);
      bsel = rows[i].addr[2] ? 8 : 0;
      chk(pinOe[bsel+:8], rows[i].oe);
      chk(pinOut[bsel+:8] & pinOe[bsel+:8], rows[i].out);
      apb(1'b0, rows[i].addr, 32'h0, rd, err);
      chk(rd, rows[i].rd);
    end
    // Unmapped address refused, nothing stored
    apb(1'b1, 12'h008, 32'hFFFFFFFF, rd, err);
    chk(err, 32'h1);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    // Read-modify-write of pin zero keeps pin four
    apb(1'b0, 12'h000, 32'h0, rd, err);
    apb(1'b1, 12'h000, rd | 32'h00010001, rd, err);
    repeat (4) @(posedge clock);
    chk(pinOe[7:0], 32'h11);
    chk(pinOut[0], 32'h1);
    // Receive pin follows pin three level
    apb(1'b1, 12'h000, 32'h0, rd, err);
    extLevel <= 16'h0008;
    repeat (4) @(posedge clock);
    chk(serialRxd, 32'h1);
    extLevel <= 16'h0000;
    repeat (4) @(posedge clock);
    chk(serialRxd, 32'h0);
    close_out();
  end
endmodule // tb
`default_nettype wire
